// [logic/ioad_regs.vh]
// register offsets, field positions, reset values and decode constants of the indexed offset decoder
`ifndef IOAD_REGS_VH
`define IOAD_REGS_VH

// register byte offsets
`define IOAD_OFS_CTRL      8'h00
`define IOAD_OFS_INSTR     8'h04
`define IOAD_OFS_BANK      8'h08
`define IOAD_OFS_PTR0      8'h0c
`define IOAD_OFS_PTR1      8'h10
`define IOAD_OFS_PTR2      8'h14
`define IOAD_OFS_RESULT    8'h18
`define IOAD_OFS_PC        8'h1c

// control register fields and reset value
`define IOAD_CTRL_EXT_BIT  0
`define IOAD_CTRL_RST      1'b0

// result register fields
`define IOAD_RES_IDX_BIT   12
`define IOAD_RES_DST_BIT   13
`define IOAD_RES_HASD_BIT  14
`define IOAD_RES_RET_BIT   15

// instruction fields
`define IOAD_EXT_OPC       8'he9
`define IOAD_SEL_HI        7
`define IOAD_SEL_LO        6
`define IOAD_SEL_RET       2'h3
`define IOAD_ACC_BIT       8
`define IOAD_DST_BIT       9

// addressing constants
`define IOAD_OFS_LIMIT     8'h5f
`define IOAD_SFR_BANK      4'hf
`define IOAD_ZERO_BANK     4'h0

// reset values
`define IOAD_PTR_RST       12'h000
`define IOAD_INSTR_RST     16'h0000
`define IOAD_BANK_RST      4'h0
`define IOAD_PC_RST        21'h000000

// cycles taken by the subtract-and-return instruction
`define IOAD_RET_CYCLES    2

`endif

// [logic/ioad_ptr_file.v]
// file-select pointer store: one write port, every entry read straight from its flops
module ioad_ptr_file #(
    parameter WIDTH = 12,
    parameter DEPTH = 3,
    parameter AW    = 2
) (
    input  wire                   pclk,     // core clock
    input  wire                   presetn,  // async reset, active low
    input  wire                   wr_en,    // write strobe
    input  wire [AW-1:0]          wr_sel,   // entry written
    input  wire [WIDTH-1:0]       wr_data,  // value written
    output wire [WIDTH*DEPTH-1:0] rd_all    // all entries, entry 0 lowest
);
    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
            reg [WIDTH-1:0] ent_r;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ent_r <= {WIDTH{1'b0}};
                end else if (wr_en && ({{(32-AW){1'b0}}, wr_sel} == i)) begin
                    ent_r <= wr_data;
                end
            end
            assign rd_all[WIDTH*i +: WIDTH] = ent_r;
        end
    endgenerate
endmodule

// [logic/ioad_core.v]
// indexed offset decoder: extended pointer instructions, operand address forming, apb registers
//
// Behaviour
// RULE1: pointer minus literal, flags untouched
// RULE2: frame subtract then return, two cycles
// RULE3: select field 11 means frame-and-return
// RULE4: extension enables indexed offset addressing too
// RULE5: disabled: access bank or bank-select addressing
// RULE6: enabled, access clear, f<=5Fh: frame offset
// RULE7: f above 5Fh stays literal access bank
// RULE8: destination bit keeps its meaning
// RULE9: frame pointer zero gives legacy addresses
// RULE10: configuration bit resets to zero, disabled
// RULE11: operand address is frame pointer plus k
// RULE12: access set always uses bank select
`include "ioad_regs.vh"

module ioad_core #(
    parameter PW = 12,
    parameter CW = 21
) (
    input  wire          pclk,          // core clock
    input  wire          presetn,       // async reset, active low
    input  wire          psel,          // apb select
    input  wire          penable,       // apb access phase
    input  wire          pwrite,        // apb direction
    input  wire [7:0]    paddr,         // apb byte address
    input  wire [31:0]   pwdata,        // apb write data
    output reg  [31:0]   prdata,        // apb read data
    output wire          pready,        // apb ready
    output wire          pslverr,       // apb error on unmapped address
    input  wire [CW-1:0] return_stack_top, // top of return stack
    output reg  [PW-1:0] opnd_addr,     // operand data address
    output reg           opnd_valid,    // operand address strobe, one cycle
    output reg           dest_to_file,  // result goes to the data location
    output reg           pc_load,       // program counter reloaded, one cycle
    output reg           stack_pop,     // return stack popped, one cycle
    output reg  [CW-1:0] pc_r,          // program counter after a return
    output wire          ext_enable     // extended set active
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_EXEC = 3'b010;
    localparam [2:0] ST_NOP  = 3'b100;

    reg  [2:0]      state_r;
    reg  [2:0]      state_nxt;
    reg             ext_r;
    reg  [15:0]     instr_r;
    reg  [3:0]      bank_select_register_r;
    reg  [PW-1:0]   res_addr_r;
    reg             res_idx_r;
    reg             res_dst_r;
    reg             res_hasd_r;
    reg             res_ret_r;
    wire [3*PW-1:0] ptr_all;
    wire [PW-1:0]   stack_frame_pointer;
    wire            acc;
    wire            wr_acc;
    wire            instr_wr;
    wire            mapped;
    wire [3:0]      opc;
    wire            is_ext;
    wire            is_ret;
    wire            uses_acc;
    wire            has_d;
    wire [7:0]      f_fld;
    wire [1:0]      sel_fld;
    wire [5:0]      lit_k;
    wire            indexed;
    wire [PW-1:0]   selected_file_pointer;
    reg  [PW-1:0]   addr_calc;
    wire            ptr_wr_en;
    wire [1:0]      ptr_wr_sel;
    wire [PW-1:0]   ptr_wr_data;
    wire            sw_ptr_wr;

    ////////////////////////////////////////////////////////////////////////////////
    // apb access decode
    assign acc      = psel & penable;
    assign wr_acc   = acc & pwrite;
    assign instr_wr = wr_acc & (paddr == `IOAD_OFS_INSTR);
    assign mapped   = (paddr == `IOAD_OFS_CTRL) | (paddr == `IOAD_OFS_INSTR) | (paddr == `IOAD_OFS_BANK) |
                      (paddr == `IOAD_OFS_PTR0) | (paddr == `IOAD_OFS_PTR1) | (paddr == `IOAD_OFS_PTR2) |
                      (paddr == `IOAD_OFS_RESULT) | (paddr == `IOAD_OFS_PC);
    // instruction writes stall until execution has finished, so nothing overlaps it
    assign pready   = ~instr_wr | (state_r[1] & ~is_ret) | state_r[2];
    assign pslverr  = acc & ~mapped;
    assign ext_enable = ext_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_r                  <= `IOAD_CTRL_RST; // RULE10
            bank_select_register_r <= `IOAD_BANK_RST;
        end else if (wr_acc && pready) begin
            if (paddr == `IOAD_OFS_CTRL) begin
                ext_r <= pwdata[`IOAD_CTRL_EXT_BIT]; // RULE10
            end
            if (paddr == `IOAD_OFS_BANK) begin
                bank_select_register_r <= pwdata[3:0];
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_r <= `IOAD_INSTR_RST;
        end else if (instr_wr && state_r[0]) begin
            instr_r <= pwdata[15:0];
        end
    end

    always @* begin
        prdata = 32'h00000000;
        if (acc && !pwrite) begin
            case (paddr)
                `IOAD_OFS_CTRL:   prdata[`IOAD_CTRL_EXT_BIT] = ext_r;
                `IOAD_OFS_INSTR:  prdata[15:0] = instr_r;
                `IOAD_OFS_BANK:   prdata[3:0] = bank_select_register_r;
                `IOAD_OFS_PTR0:   prdata[PW-1:0] = ptr_all[PW-1:0];
                `IOAD_OFS_PTR1:   prdata[PW-1:0] = ptr_all[2*PW-1:PW];
                `IOAD_OFS_PTR2:   prdata[PW-1:0] = ptr_all[3*PW-1:2*PW];
                `IOAD_OFS_RESULT: prdata[15:0] = {res_ret_r, res_hasd_r, res_dst_r, res_idx_r, res_addr_r};
                `IOAD_OFS_PC:     prdata[CW-1:0] = pc_r;
                default:          prdata = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // instruction field decode
    assign opc      = instr_r[15:12];
    assign f_fld    = instr_r[7:0];
    assign sel_fld  = instr_r[`IOAD_SEL_HI:`IOAD_SEL_LO];
    assign lit_k    = instr_r[5:0];
    // extended encodings only exist while the configuration bit is set
    assign is_ext   = ext_r & (instr_r[15:8] == `IOAD_EXT_OPC); // RULE4
    assign is_ret   = is_ext & (sel_fld == `IOAD_SEL_RET); // RULE3
    // byte- and bit-oriented groups carry the access bit
    assign uses_acc = ~is_ext & (((opc >= 4'h1) & (opc <= 4'hb)) | ((opc == 4'h0) & (instr_r[11:9] != 3'h0)));
    assign has_d    = ((opc >= 4'h1) & (opc <= 4'h5)) | ((opc == 4'h0) & (instr_r[11:10] == 2'h1));
    assign indexed  = ext_r & ~instr_r[`IOAD_ACC_BIT] & (f_fld <= `IOAD_OFS_LIMIT); // RULE4 RULE6 RULE7

    assign stack_frame_pointer   = ptr_all[3*PW-1:2*PW];
    // select 11 is forced onto the frame pointer
    assign selected_file_pointer = is_ret ? stack_frame_pointer : ptr_all[PW*sel_fld[1:0] +: PW]; // RULE3

    always @* begin
        if (instr_r[`IOAD_ACC_BIT]) begin
            addr_calc = {bank_select_register_r, f_fld}; // RULE5 RULE12
        end else if (indexed) begin
            // a zero frame pointer lands exactly on the legacy low access bank
            addr_calc = stack_frame_pointer + {{(PW-8){1'b0}}, f_fld}; // RULE6 RULE11 RULE9
        end else if (f_fld <= `IOAD_OFS_LIMIT) begin
            addr_calc = {`IOAD_ZERO_BANK, f_fld}; // RULE5
        end else begin
            addr_calc = {`IOAD_SFR_BANK, f_fld}; // RULE7
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // execution sequence
    always @* begin
        case (state_r)
            ST_IDLE: state_nxt = instr_wr ? ST_EXEC : ST_IDLE;
            ST_EXEC: state_nxt = is_ret ? ST_NOP : ST_IDLE; // RULE2
            ST_NOP:  state_nxt = ST_IDLE; // RULE2
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // pointer writes: software in idle, subtraction during execute
    assign sw_ptr_wr   = wr_acc & state_r[0] &
                         ((paddr == `IOAD_OFS_PTR0) | (paddr == `IOAD_OFS_PTR1) | (paddr == `IOAD_OFS_PTR2));
    assign ptr_wr_en   = sw_ptr_wr | (state_r[1] & is_ext); // RULE1
    assign ptr_wr_sel  = sw_ptr_wr ? ((paddr == `IOAD_OFS_PTR0) ? 2'h0 : (paddr == `IOAD_OFS_PTR1) ? 2'h1 : 2'h2) :
                         (is_ret ? 2'h2 : sel_fld);
    assign ptr_wr_data = sw_ptr_wr ? pwdata[PW-1:0] :
                         (selected_file_pointer - {{(PW-6){1'b0}}, lit_k}); // RULE1 RULE2

    ioad_ptr_file #(
        .WIDTH (PW),
        .DEPTH (3),
        .AW    (2)
    ) u_ptr (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (ptr_wr_en),
        .wr_sel  (ptr_wr_sel),
        .wr_data (ptr_wr_data),
        .rd_all  (ptr_all)
    );

    // outputs toward data memory and the return stack; no status flag is ever driven here
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opnd_addr    <= `IOAD_PTR_RST;
            opnd_valid   <= 1'b0;
            dest_to_file <= 1'b0;
            pc_load      <= 1'b0;
            stack_pop    <= 1'b0;
            pc_r         <= `IOAD_PC_RST;
            res_addr_r   <= `IOAD_PTR_RST;
            res_idx_r    <= 1'b0;
            res_dst_r    <= 1'b0;
            res_hasd_r   <= 1'b0;
            res_ret_r    <= 1'b0;
        end else begin
            opnd_valid <= state_r[1] & uses_acc;
            pc_load    <= state_r[1] & is_ret; // RULE2
            stack_pop  <= state_r[1] & is_ret; // RULE2
            if (state_r[1]) begin
                res_ret_r  <= is_ret;
                res_hasd_r <= uses_acc & has_d;
                res_idx_r  <= uses_acc & indexed;
                if (uses_acc) begin
                    opnd_addr    <= addr_calc; // RULE11
                    res_addr_r   <= addr_calc;
                    // d only picks working register or file, indexed or not
                    dest_to_file <= has_d ? instr_r[`IOAD_DST_BIT] : 1'b1; // RULE8
                    res_dst_r    <= has_d ? instr_r[`IOAD_DST_BIT] : 1'b1; // RULE8
                end
                if (is_ret) begin
                    pc_r <= return_stack_top; // RULE2
                end
            end
        end
    end
endmodule

// [testbench/ioad_assertions.sv]
// concurrent checks on the ports of the indexed offset decoder
module ioad_assertions #(
    parameter PW = 12,
    parameter CW = 21
) (
    input wire          pclk,             // clock
    input wire          presetn,          // async reset, low
    input wire          psel,             // apb select
    input wire          penable,          // apb access
    input wire          pwrite,           // apb direction
    input wire [7:0]    paddr,            // apb address
    input wire [31:0]   pwdata,           // apb write data
    input wire          pready,           // apb ready
    input wire [CW-1:0] return_stack_top, // stack top
    input wire [PW-1:0] opnd_addr,        // operand address
    input wire          opnd_valid,       // operand strobe
    input wire          dest_to_file,     // destination
    input wire          pc_load,          // pc reload
    input wire          stack_pop,        // stack pop
    input wire [CW-1:0] pc_r,             // program counter
    input wire          ext_enable        // extension on
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////
    // the instruction word was on pwdata at the edge before opnd_valid
    sequence s_stall;
        psel && penable && !pready;
    endsequence
    sequence s_ret_wait;
        s_stall [*2];
    endsequence
    AST_RET_AFTER_WAITS: assert property (s_ret_wait |=> pc_load && stack_pop)
        else $error("return not completed after two waits");
    AST_RET_TOS: assert property (pc_load |-> stack_pop && pc_r == $past(return_stack_top))
        else $error("pc not loaded from stack top");
    AST_RET_ONE_CYCLE: assert property (pc_load |=> !pc_load && !stack_pop)
        else $error("return strobe longer than one cycle");
    AST_CFG_WRITE: assert property ($changed(ext_enable) |->
        $past(psel && penable && pwrite && pready && paddr == 8'h00) && ext_enable == $past(pwdata[0]))
        else $error("extension bit changed without a control write");
    AST_HIGH_LITERAL: assert property (opnd_valid && !$past(pwdata[8]) && $past(pwdata[7:0]) > 8'h5f
        |-> opnd_addr == {4'hf, $past(pwdata[7:0])})
        else $error("high access address not literal");
    AST_LEGACY_LOW: assert property (opnd_valid && !ext_enable && !$past(pwdata[8]) && $past(pwdata[7:0]) <= 8'h5f
        |-> opnd_addr == {4'h0, $past(pwdata[7:0])})
        else $error("legacy low access address wrong");
    AST_BANK_OFFSET: assert property (opnd_valid && $past(pwdata[8]) |-> opnd_addr[7:0] == $past(pwdata[7:0]))
        else $error("banked address low byte wrong");
    AST_DEST_KEPT: assert property (opnd_valid && $past(pwdata[15:12]) == 4'h2 |-> dest_to_file == $past(pwdata[9]))
        else $error("destination bit not followed");
endmodule

// [testbench/ioad_stack_model.sv]
// return stack beside the decoder: top entry, popped on each return
module ioad_stack_model #(
    parameter          CW   = 21,
    parameter [CW-1:0] TOS0 = 21'h00abc4  // first return address, arbitrary
) (
    input  wire          pclk,             // clock
    input  wire          presetn,          // async reset, low
    input  wire          stack_pop,        // pop strobe
    output reg  [CW-1:0] return_stack_top  // top entry
);
    timeunit 1ns;
    timeprecision 1ps;
    // a pop exposes a different entry, so a late sample of the top shows up
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            return_stack_top <= TOS0;
        end else if (stack_pop) begin
            return_stack_top <= return_stack_top - 21'h000010;
        end
    end
endmodule

// [testbench/tb_top.sv]
// testbench of the indexed offset decoder driven over apb
`include "ioad_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam          PW   = 12;
    localparam          CW   = 21;
    localparam [CW-1:0] TOS0 = 21'h00abc4;  // arbitrary
    logic          pclk = 1'b0;
    logic          presetn, psel, penable, pwrite, last_err;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, rdata;
    logic [12:0]   cap;
    wire  [31:0]   prdata;
    wire           pready, pslverr, opnd_valid, dest_to_file, pc_load, stack_pop, ext_enable;
    wire  [PW-1:0] opnd_addr;
    wire  [CW-1:0] return_stack_top, pc_r;
    integer        err_total, checked, pops;
    always #12.5 pclk = ~pclk;
    ioad_core #(.PW(PW), .CW(CW)) i_ioad_core (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .return_stack_top(return_stack_top), .opnd_addr(opnd_addr), .opnd_valid(opnd_valid),
        .dest_to_file(dest_to_file), .pc_load(pc_load), .stack_pop(stack_pop), .pc_r(pc_r),
        .ext_enable(ext_enable));
    ioad_stack_model #(.CW(CW), .TOS0(TOS0)) i_ioad_stack_model (.pclk(pclk), .presetn(presetn),
        .stack_pop(stack_pop), .return_stack_top(return_stack_top));
    always @(posedge pclk) begin
        if (opnd_valid === 1'b1) cap <= {dest_to_file, opnd_addr};
        if (pc_load === 1'b1) pops <= pops + 1;
    end
    ////////////////////////////////////////////////////////////
    task give_verdict;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // request stands until ready is seen high at a rising edge; data and error are taken at that edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            give_verdict;
        end else begin
            rdata = prdata;
            last_err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rdata, exp);
    endtask
    task ex(input logic [15:0] ins, input logic [12:0] exp);
        // unknown until a strobe lands, so a missing operand cannot pass on a stale capture
        cap = 'x;
        apb(1'b1, `IOAD_OFS_INSTR, {16'h0, ins});
        repeat (2) @(posedge pclk);
        chk("operand", {19'h0, cap}, {19'h0, exp});
    endtask
    task sub(input logic [1:0] s, input logic [11:0] base, input logic [5:0] k, input logic [11:0] exp);
        apb(1'b1, `IOAD_OFS_PTR0 + {4'h0, s, 2'b00}, {20'h0, base});
        apb(1'b1, `IOAD_OFS_INSTR, {16'h0, 8'he9, s, k});
        rd(`IOAD_OFS_PTR0 + {4'h0, s, 2'b00}, {20'h0, exp}, "pointer");
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        err_total = 0;
        checked = 0;
        pops = 0;
        cap = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(`IOAD_OFS_CTRL, 32'h0, "ctrl");
        chk("ext", {31'h0, ext_enable}, 32'h0);
        apb(1'b1, `IOAD_OFS_BANK, 32'h5);
        ex(16'h2412, 13'h0012);
        ex(16'h2680, 13'h1f80);
        ex(16'h2512, 13'h0512);
        sub(2'h0, 12'h010, 6'h3f, 12'h010);
        apb(1'b1, `IOAD_OFS_CTRL, 32'h1);
        rd(`IOAD_OFS_CTRL, 32'h1, "ctrl");
        chk("ext", {31'h0, ext_enable}, 32'h1);
        apb(1'b1, `IOAD_OFS_PTR2, 32'h0);
        ex(16'h2412, 13'h0012);
        apb(1'b1, `IOAD_OFS_PTR2, 32'ha00);
        ex(16'h2612, 13'h1a12);
        ex(16'h245f, 13'h0a5f);
        ex(16'h2460, 13'h0f60);
        ex(16'h2712, 13'h1512);
        ex(16'h8012, 13'h1a12);
        rd(`IOAD_OFS_RESULT, 32'h3a12, "result");
        sub(2'h0, 12'h010, 6'h3f, 12'hfd1);
        sub(2'h1, 12'h100, 6'h05, 12'h0fb);
        sub(2'h2, 12'h3ff, 6'h23, 12'h3dc);
        apb(1'b1, `IOAD_OFS_PTR2, 32'h3ff);
        apb(1'b1, `IOAD_OFS_INSTR, 32'he9e3);
        rd(`IOAD_OFS_PTR2, 32'h3dc, "frame");
        rd(`IOAD_OFS_PC, {11'h0, TOS0}, "pc");
        chk("returns", pops, 32'h1);
        rd(8'h20, 32'h0, "unmapped");
        chk("slverr", {31'h0, last_err}, 32'h1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("ext", {31'h0, ext_enable}, 32'h0);
        presetn <= 1'b1;
        rd(`IOAD_OFS_CTRL, 32'h0, "ctrl");
        ex(16'h2412, 13'h0012);
        give_verdict;
    end
endmodule
bind ioad_core ioad_assertions #(.PW(PW), .CW(CW)) i_ioad_assertions (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .return_stack_top(return_stack_top), .opnd_addr(opnd_addr), .opnd_valid(opnd_valid),
    .dest_to_file(dest_to_file), .pc_load(pc_load), .stack_pop(stack_pop), .pc_r(pc_r), .ext_enable(ext_enable));
